// *** dv/mbdp_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module mbdp_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ale,
  input wire logic rd_e,
  input wire logic wr_rw,
  input wire logic psen_n,
  input wire logic host_ad_oe,
  input wire logic dev_ad_oe,
  input wire logic rst_out,
  input wire logic reset_in_n,
  input wire logic cfg_ecl_mode
);
  logic strb;
  logic rdc;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Strobe and read qualifiers as the device sees them in its configured host style.
  assign strb = cfg_ecl_mode ? rd_e : (!rd_e || !wr_rw || !psen_n);
  assign rdc = cfg_ecl_mode ? (rd_e && wr_rw) : (!rd_e || !psen_n);
  rst_follow_a: assert property (rst_out == !reset_in_n)
    else $error("reset output is not the inverse of the reset input");
  latch_phase_a: assert property (ale |-> host_ad_oe ##1 (!ale && host_ad_oe))
    else $error("address not held around the latch strobe");
  strobe_len_a: assert property ($fell(ale) |=> strb [*3] ##1 !strb)
    else $error("strobe phase is not three cycles long");
  strobe_addr_a: assert property (ale |-> !strb)
    else $error("strobe active during the address phase");
  one_strobe_a: assert property (!cfg_ecl_mode |-> $onehot0({!rd_e, !wr_rw, !psen_n}))
    else $error("more than one strobe active");
  eclk_fetch_a: assert property (cfg_ecl_mode |-> psen_n)
    else $error("fetch strobe used by the E clock host");
  no_fight_a: assert property (!(host_ad_oe && dev_ad_oe))
    else $error("both ends drive the byte bus");
  drive_read_a: assert property (dev_ad_oe |-> $past(rdc) && !$past(ale))
    else $error("device drives the bus outside a read");
  read_release_a: assert property ($fell(strb) |=> !dev_ad_oe)
    else $error("device keeps driving after the strobe ends");
  write_drive_a: assert property ((cfg_ecl_mode ? (rd_e && !wr_rw) : !wr_rw) |-> host_ad_oe)
    else $error("write strobe without host data on the bus");
endmodule : mbdp_properties
`default_nettype wire

// *** dv/mcu_bus_decode_port_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module mcu_bus_decode_port_bench;
  logic aclk, aresetn, reset_in_n, cfg_ecl_mode, cfg_rd_eprom, cfg_overlap, strb_ff;
  logic [7:0] s_axi_awaddr, s_axi_araddr, eprom_rdata, io_rdata, io_addr, io_wdata, ext_addr_lo;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, r;
  logic [3:0] s_axi_wstrb, pulses_ff;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, io_wr_pulse, ext_cs_n, ext_rd_n, ext_wr_n;
  logic eprom_block0_sel, eprom_block1_sel, eprom_block2_sel, eprom_block3_sel, sram_sel, io_sel;
  logic [13:0] eprom_addr;
  logic [5:0] seen_ff;
  logic [2:0] xs_ff, mode;
  logic [15:0] sa [4];
  logic [7:0] sd [4];
  int failures, checks;
  // Each entry is {mode e,c,o; command; address}.
  logic [20:0] tbl [24] = '{21'h20123, 21'h25555, 21'h29abc, 21'h2f000, 21'h04321, 21'h02345, 21'h0c0aa,
    21'ha0123, 21'h85555, 21'h89abc, 21'h8c0aa, 21'h82345, 21'he1234, 21'hc1234, 21'he5678, 21'hc5678,
    21'hc9abc, 21'h100080, 21'h104444, 21'h108000, 21'h10c123, 21'h100500, 21'h112100, 21'h102200};

  mbdp_bus_if u_mbdp_bus_if ();
  mbdp_host u_mbdp_host (.aclk, .aresetn, .bus(u_mbdp_bus_if), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  mbdp_device u_mbdp_device (.aclk, .aresetn, .bus(u_mbdp_bus_if), .reset_in_n, .cfg_ecl_mode, .cfg_rd_eprom,
    .cfg_overlap, .eprom_block0_sel, .eprom_block1_sel, .eprom_block2_sel, .eprom_block3_sel, .sram_sel, .io_sel,
    .eprom_addr, .eprom_rdata, .io_rdata, .io_addr, .io_wdata, .io_wr_pulse, .ext_addr_lo, .ext_cs_n, .ext_rd_n,
    .ext_wr_n);
  mbdp_properties u_mbdp_properties (.aclk, .aresetn, .ale(u_mbdp_bus_if.ale), .rd_e(u_mbdp_bus_if.rd_e),
    .wr_rw(u_mbdp_bus_if.wr_rw), .psen_n(u_mbdp_bus_if.psen_n), .host_ad_oe(u_mbdp_bus_if.host_ad_oe),
    .dev_ad_oe(u_mbdp_bus_if.dev_ad_oe), .rst_out(u_mbdp_bus_if.rst_out), .reset_in_n, .cfg_ecl_mode);

  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Collects what the device shows while a strobe is active, one edge late like its outputs.
  always @(posedge aclk)
  begin
    strb_ff <= cfg_ecl_mode ? u_mbdp_bus_if.rd_e
      : !(u_mbdp_bus_if.rd_e && u_mbdp_bus_if.wr_rw && u_mbdp_bus_if.psen_n);
    if (strb_ff)
      seen_ff <= seen_ff | {io_sel, sram_sel, eprom_block3_sel, eprom_block2_sel, eprom_block1_sel, eprom_block0_sel};
    if (strb_ff)
      xs_ff <= xs_ff | ~{ext_wr_n, ext_rd_n, ext_cs_n};
    if (io_wr_pulse)
      pulses_ff <= pulses_ff + 4'h1;
  end

  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : next_rand

  function automatic logic [5:0] exp_sel(input logic [2:0] m, input logic [1:0] k, input logic [15:0] a);
    if (m[2])
    begin
      if (a <= 16'h00ff) return 6'h20;
      if (a >= 16'h1000 && a <= 16'h13ff) return 6'h10;
      if (a >= 16'h4000) return 6'h01 << a[15:14];
      return 6'h00;
    end
    if (k != 2'h2 && a <= 16'h03ff) return 6'h10;
    // In combined space without overlap a data read of the I/O block also hits the top EPROM block.
    if (k != 2'h2 && a[15:8] == 8'hc0) return (k == 2'h0 && m[1:0] == 2'b10) ? 6'h28 : 6'h20;
    if (k == 2'h1 || (k == 2'h0 && !m[1])) return 6'h00;
    if (m[1:0] == 2'b11) return a[15] ? 6'h00 : 6'h01 << {k == 2'h0, a[14]};
    return 6'h01 << a[15:14];
  endfunction : exp_sel

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (e !== g)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic set_mode(input logic [2:0] m);
    axi_wr(mbdp_pkg::REG_MODE, {31'h0, m[2]});
    {cfg_ecl_mode, cfg_rd_eprom, cfg_overlap} <= m;
    mode = m;
  endtask : set_mode

  // Runs one link cycle; for a read of SRAM, d is the byte expected back.
  task automatic cyc(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
    logic [31:0] v;
    logic [5:0] es;
    logic [7:0] erd;
    v = next_rand();
    eprom_rdata <= v[7:0];
    io_rdata <= v[15:8];
    axi_wr(mbdp_pkg::REG_ADDR, {16'h0, a});
    axi_wr(mbdp_pkg::REG_WDATA, {24'h0, d});
    seen_ff <= '0;
    xs_ff <= '0;
    pulses_ff <= '0;
    axi_wr(mbdp_pkg::REG_CMD, {30'h0, k});
    do axi_rd(mbdp_pkg::REG_STATUS, v); while (v[0] !== 1'b0);
    axi_rd(mbdp_pkg::REG_RDATA, v);
    es = exp_sel(mode, k, a);
    erd = es[5] ? io_rdata : (es[4] ? d : ((|es[3:0]) ? eprom_rdata : 8'hff));
    if (k != 2'h1) chk("read data", erd, v[7:0]);
    chk("selects", es, seen_ff);
    chk("ext select", es == 6'h0 && k != 2'h2 && a[15:13] == 3'b001, xs_ff[0]);
    if (mode[2]) chk("ext strobes", {k == 2'h1, k == 2'h0}, xs_ff[2:1]);
    chk("low address", a[7:0], ext_addr_lo);
    chk("eprom address", a[13:0], eprom_addr);
  endtask : cyc

  task automatic complete_run();
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (20000) @(posedge aclk);
    failures++;
    complete_run();
  end

  initial
  begin
    seed = 32'h83f7;
    failures = 0;
    checks = 0;
    {aresetn, reset_in_n, cfg_ecl_mode, cfg_rd_eprom, cfg_overlap, strb_ff} = 6'b010000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'b0;
    {s_axi_awaddr, s_axi_araddr, eprom_rdata, io_rdata} = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {seen_ff, xs_ff, pulses_ff, mode} = 16'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(mbdp_pkg::REG_STATUS, r);
    chk("status idle", 32'h0, r);
    reset_in_n <= 1'b0;
    axi_rd(mbdp_pkg::REG_STATUS, r);
    chk("status in reset", 32'h2, r);
    axi_wr(mbdp_pkg::REG_CMD, 32'h0);
    chk("cmd in reset", mbdp_pkg::RESP_SLVERR, resp);
    reset_in_n <= 1'b1;
    axi_wr(8'h3c, 32'h0);
    chk("unmapped", mbdp_pkg::RESP_SLVERR, resp);
    foreach (tbl[i])
    begin
      if (tbl[i][20:18] != mode) set_mode(tbl[i][20:18]);
      cyc(tbl[i][17:16], tbl[i][15:0], 8'h00);
    end
    for (int j = 0; j < 2; j++)
    begin
      set_mode(j ? 3'b100 : 3'b000);
      for (int i = 0; i < 4; i++)
      begin
        r = next_rand();
        sa[i] = (j ? 16'h1000 : 16'h0000) | {6'h0, 2'(i), r[7:0]};
        sd[i] = r[23:16];
        cyc(2'h1, sa[i], sd[i]);
      end
      foreach (sa[i]) cyc(2'h0, sa[i], sd[i]);
    end
    set_mode(3'b000);
    r = next_rand();
    cyc(2'h1, {8'hc0, r[7:0]}, r[15:8]);
    chk("io pulses", 4'h1, pulses_ff);
    chk("io data", r[15:8], io_wdata);
    chk("io address", r[7:0], io_addr);
    complete_run();
  end
endmodule : mcu_bus_decode_port_bench
`default_nettype wire

// *** rtl/mbdp_bus_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface mbdp_bus_if;
  logic ale;
  logic rd_e;
  logic wr_rw;
  logic psen_n;
  logic [7:0] addr_hi;
  logic [7:0] host_ad_o;
  logic host_ad_oe;
  logic [7:0] dev_ad_o;
  logic dev_ad_oe;
  logic [7:0] addr_data_low_port;
  logic rst_out;

  // Resolved bus level; an undriven bus reads as pulled high.
  assign addr_data_low_port = host_ad_oe ? host_ad_o : (dev_ad_oe ? dev_ad_o : 8'hff);

  modport host (
    output ale,
    output rd_e,
    output wr_rw,
    output psen_n,
    output addr_hi,
    output host_ad_o,
    output host_ad_oe,
    input addr_data_low_port,
    input rst_out
  );

  modport dev (
    input ale,
    input rd_e,
    input wr_rw,
    input psen_n,
    input addr_hi,
    output dev_ad_o,
    output dev_ad_oe,
    input addr_data_low_port,
    output rst_out
  );
endinterface : mbdp_bus_if
`default_nettype wire

// *** rtl/mbdp_decoder.sv ***
`timescale 1ns/100ps
`default_nettype none
module mbdp_decoder (
  input wire logic [15:0] addr,
  input wire logic ecl_mode,
  input wire logic rd_eprom,
  input wire logic overlap,
  input wire logic code_cyc,
  input wire logic rd_cyc,
  input wire logic wr_cyc,
  output logic [mbdp_pkg::SEL_W-1:0] sel,
  output logic ext_hit
);
  logic data_cyc;
  logic ep_cyc;
  logic [1:0] blk;

  always_comb
  begin
    sel = '0;
    data_cyc = rd_cyc | wr_cyc;
    ep_cyc = 1'b0;
    blk = addr[mbdp_pkg::BLK_LSB +: 2];
    if (ecl_mode)
    begin
      sel[mbdp_pkg::SEL_IO] = mbdp_pkg::in_rng(addr, mbdp_pkg::EC_IO_LO, mbdp_pkg::EC_IO_HI) & data_cyc;
      sel[mbdp_pkg::SEL_SRAM] = mbdp_pkg::in_rng(addr, mbdp_pkg::EC_SRAM_LO, mbdp_pkg::EC_SRAM_HI) & data_cyc;
      for (int b = 1; b < mbdp_pkg::EPROM_BLKS; b++)
      begin
        sel[b] = (blk == 2'(b)) & data_cyc;
      end
    end
    else
    begin
      sel[mbdp_pkg::SEL_IO] = mbdp_pkg::in_rng(addr, mbdp_pkg::STB_IO_LO, mbdp_pkg::STB_IO_HI) & data_cyc;
      sel[mbdp_pkg::SEL_SRAM] = mbdp_pkg::in_rng(addr, mbdp_pkg::STB_SRAM_LO, mbdp_pkg::STB_SRAM_HI)
        & data_cyc;
      // A data read reaches the EPROM only in combined space.
      ep_cyc = code_cyc | (rd_eprom & rd_cyc);
      if (rd_eprom && overlap)
      begin
        // The read strobe acts as an address bit, so access time runs from its assertion.
        sel[0] = mbdp_pkg::in_rng(addr, mbdp_pkg::OVL_LO0, mbdp_pkg::OVL_HI0) & code_cyc;
        sel[1] = mbdp_pkg::in_rng(addr, mbdp_pkg::OVL_LO1, mbdp_pkg::OVL_HI1) & code_cyc;
        sel[2] = mbdp_pkg::in_rng(addr, mbdp_pkg::OVL_LO0, mbdp_pkg::OVL_HI0) & rd_cyc;
        sel[3] = mbdp_pkg::in_rng(addr, mbdp_pkg::OVL_LO1, mbdp_pkg::OVL_HI1) & rd_cyc;
      end
      else
      begin
        for (int b = 0; b < mbdp_pkg::EPROM_BLKS; b++)
        begin
          sel[b] = (blk == 2'(b)) & ep_cyc;
        end
      end
      // Data cycles that hit the SRAM window never reach an overlapping EPROM block.
      if (sel[mbdp_pkg::SEL_SRAM])
      begin
        sel[mbdp_pkg::EPROM_BLKS-1:0] = '0;
      end
    end
    ext_hit = mbdp_pkg::in_rng(addr, mbdp_pkg::EXT_LO, mbdp_pkg::EXT_HI) & data_cyc & ~(|sel);
  end
endmodule : mbdp_decoder
`default_nettype wire

// *** rtl/mbdp_device.sv ***
`timescale 1ns/100ps
`default_nettype none
// Function
// - Read-EPROM option selects combined space mode
// - Otherwise separated mode: only fetch reads EPROM
// - Separated mode: data reads reach SRAM and I/O, not EPROM
// - Strobe host: byte bus, multiplexed, high latch
// - Strobe map: four 16K blocks, SRAM, I/O
// - Overlap: blocks 0-1 fetch, 2-3 read
// - Read strobe used as a decode input
// - Reset output is inverse of reset input
// - E-clock host: read pin E, write R/W
// - E high, R/W high: read, drive if selected
// - R/W low writes data into selected SRAM
// - E-clock host: byte, multiplexed, high strobe
// - E-clock map: I/O, SRAM, blocks 1-3
// - Latched low address byte output for external SRAM
// - External SRAM select from decoded address
// - External SRAM strobes from E and R/W
module mbdp_device #(
  parameter int unsigned SRAM_DEPTH = mbdp_pkg::SRAM_DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  mbdp_bus_if.dev bus,
  input wire logic reset_in_n,
  input wire logic cfg_ecl_mode,
  input wire logic cfg_rd_eprom,
  input wire logic cfg_overlap,
  output logic eprom_block0_sel,
  output logic eprom_block1_sel,
  output logic eprom_block2_sel,
  output logic eprom_block3_sel,
  output logic sram_sel,
  output logic io_sel,
  output logic [13:0] eprom_addr,
  input wire logic [7:0] eprom_rdata,
  input wire logic [7:0] io_rdata,
  output logic [7:0] io_addr,
  output logic [7:0] io_wdata,
  output logic io_wr_pulse,
  output logic [7:0] ext_addr_lo,
  output logic ext_cs_n,
  output logic ext_rd_n,
  output logic ext_wr_n
);
  localparam int unsigned IDX_W = $clog2(SRAM_DEPTH);

  logic code_cyc;
  logic rd_cyc;
  logic wr_cyc;
  logic [15:0] addr;
  logic [mbdp_pkg::SEL_W-1:0] sel;
  logic ext_hit;
  logic any_sel;
  logic [7:0] nxt_ad_o;
  logic [IDX_W-1:0] sram_idx;

  logic [7:0] addr_lo_ff;
  logic [mbdp_pkg::SEL_W-1:0] sel_ff;
  logic [7:0] ad_o_ff;
  logic ad_oe_ff;
  logic [7:0] sram_mem [SRAM_DEPTH];
  logic io_wr_prev_ff;
  logic io_wr_pulse_ff;
  logic [7:0] io_addr_ff;
  logic [7:0] io_wdata_ff;
  logic ext_cs_n_ff;
  logic ext_rd_n_ff;
  logic ext_wr_n_ff;

  // Strobe interpretation depends on the host style.
  always_comb
  begin
    if (cfg_ecl_mode)
    begin
      code_cyc = 1'b0;
      rd_cyc = bus.rd_e & bus.wr_rw;
      wr_cyc = bus.rd_e & ~bus.wr_rw;
    end
    else
    begin
      code_cyc = ~bus.psen_n;
      rd_cyc = ~bus.rd_e;
      wr_cyc = ~bus.wr_rw;
    end
  end

  // The low address byte is captured while the latch strobe is high.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      addr_lo_ff <= 8'h00;
    end
    else if (bus.ale)
    begin
      addr_lo_ff <= bus.addr_data_low_port;
    end
  end

  assign addr = {bus.addr_hi, addr_lo_ff};
  assign sram_idx = addr[IDX_W-1:0];
  assign eprom_addr = addr[13:0];
  assign ext_addr_lo = addr_lo_ff;

  mbdp_decoder u_dec (
    .addr(addr),
    .ecl_mode(cfg_ecl_mode),
    .rd_eprom(cfg_rd_eprom),
    .overlap(cfg_overlap),
    .code_cyc(code_cyc),
    .rd_cyc(rd_cyc),
    .wr_cyc(wr_cyc),
    .sel(sel),
    .ext_hit(ext_hit)
  );

  assign any_sel = |sel;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sel_ff <= '0;
    end
    else
    begin
      sel_ff <= sel;
    end
  end

  assign eprom_block0_sel = sel_ff[0];
  assign eprom_block1_sel = sel_ff[1];
  assign eprom_block2_sel = sel_ff[2];
  assign eprom_block3_sel = sel_ff[3];
  assign sram_sel = sel_ff[mbdp_pkg::SEL_SRAM];
  assign io_sel = sel_ff[mbdp_pkg::SEL_IO];

  // Read data source follows the current decode.
  always_comb
  begin
    if (sel[mbdp_pkg::SEL_SRAM])
    begin
      nxt_ad_o = sram_mem[sram_idx];
    end
    else if (sel[mbdp_pkg::SEL_IO])
    begin
      nxt_ad_o = io_rdata;
    end
    else
    begin
      nxt_ad_o = eprom_rdata;
    end
  end

  // The port drives only on a read or fetch that hits an internal device.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ad_o_ff <= 8'h00;
      ad_oe_ff <= 1'b0;
    end
    else
    begin
      ad_o_ff <= nxt_ad_o;
      ad_oe_ff <= (rd_cyc | code_cyc) & any_sel & ~bus.ale;
    end
  end

  assign bus.dev_ad_o = ad_o_ff;
  assign bus.dev_ad_oe = ad_oe_ff;

  // SRAM contents are not cleared by reset.
  always_ff @(posedge aclk)
  begin
    if (wr_cyc && sel[mbdp_pkg::SEL_SRAM])
    begin
      sram_mem[sram_idx] <= bus.addr_data_low_port;
    end
  end

  // One pulse per I/O write, carrying the byte seen when the write began.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      io_wr_prev_ff <= 1'b0;
      io_wr_pulse_ff <= 1'b0;
      io_addr_ff <= 8'h00;
      io_wdata_ff <= 8'h00;
    end
    else
    begin
      io_wr_prev_ff <= wr_cyc & sel[mbdp_pkg::SEL_IO];
      io_wr_pulse_ff <= wr_cyc & sel[mbdp_pkg::SEL_IO] & ~io_wr_prev_ff;
      if (wr_cyc && sel[mbdp_pkg::SEL_IO] && !io_wr_prev_ff)
      begin
        io_addr_ff <= addr[7:0];
        io_wdata_ff <= bus.addr_data_low_port;
      end
    end
  end

  assign io_wr_pulse = io_wr_pulse_ff;
  assign io_addr = io_addr_ff;
  assign io_wdata = io_wdata_ff;

  // External SRAM controls; strobes are active low.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_cs_n_ff <= 1'b1;
      ext_rd_n_ff <= 1'b1;
      ext_wr_n_ff <= 1'b1;
    end
    else
    begin
      ext_cs_n_ff <= ~ext_hit;
      ext_rd_n_ff <= ~rd_cyc;
      ext_wr_n_ff <= ~wr_cyc;
    end
  end

  assign ext_cs_n = ext_cs_n_ff;
  assign ext_rd_n = ext_rd_n_ff;
  assign ext_wr_n = ext_wr_n_ff;

  assign bus.rst_out = ~reset_in_n;
endmodule : mbdp_device
`default_nettype wire

// *** rtl/mbdp_host.sv ***
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module mbdp_host (
  input wire logic aclk,
  input wire logic aresetn,
  mbdp_bus_if.host bus,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  mbdp_pkg::mbdp_hstate_t st_ff;
  mbdp_pkg::mbdp_cmd_t cmd_ff;
  logic [1:0] cnt_ff;
  logic [15:0] addr_ff;
  logic [7:0] wdata_ff;
  logic [7:0] rdata_ff;
  logic ecl_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdat_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_out_ff;
  logic [1:0] rresp_ff;
  logic do_wr;
  logic start;
  logic strb;
  logic is_wr;

  assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_got_ff & ~bvalid_ff;
  assign do_wr = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign start = do_wr & (awaddr_ff == mbdp_pkg::REG_CMD) & (st_ff == mbdp_pkg::HS_IDLE) & ~bus.rst_out;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdat_ff <= 32'h0000_0000;
      bvalid_ff <= 1'b0;
      bresp_ff <= mbdp_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_ff <= 1'b1;
        wdat_ff <= s_axi_wdata;
      end
      if (do_wr)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        case (awaddr_ff)
          mbdp_pkg::REG_CMD: bresp_ff <= start ? mbdp_pkg::RESP_OKAY : mbdp_pkg::RESP_SLVERR;
          mbdp_pkg::REG_ADDR, mbdp_pkg::REG_WDATA, mbdp_pkg::REG_MODE: bresp_ff <= mbdp_pkg::RESP_OKAY;
          default: bresp_ff <= mbdp_pkg::RESP_SLVERR;
        endcase
      end
      else if (bvalid_ff && s_axi_bready)
      begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // Settings registers take whole words; byte lane strobes are ignored.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      addr_ff <= 16'h0000;
      wdata_ff <= 8'h00;
      ecl_ff <= 1'b0;
    end
    else if (do_wr && st_ff == mbdp_pkg::HS_IDLE)
    begin
      if (awaddr_ff == mbdp_pkg::REG_ADDR)
      begin
        addr_ff <= wdat_ff[15:0];
      end
      if (awaddr_ff == mbdp_pkg::REG_WDATA)
      begin
        wdata_ff <= wdat_ff[7:0];
      end
      if (awaddr_ff == mbdp_pkg::REG_MODE)
      begin
        ecl_ff <= wdat_ff[0];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_out_ff <= 32'h0000_0000;
      rresp_ff <= mbdp_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff <= mbdp_pkg::RESP_OKAY;
      case (s_axi_araddr)
        mbdp_pkg::REG_ADDR: rdata_out_ff <= {16'h0000, addr_ff};
        mbdp_pkg::REG_WDATA: rdata_out_ff <= {24'h000000, wdata_ff};
        mbdp_pkg::REG_RDATA: rdata_out_ff <= {24'h000000, rdata_ff};
        mbdp_pkg::REG_STATUS: rdata_out_ff <= {30'h0000_0000, bus.rst_out, st_ff != mbdp_pkg::HS_IDLE};
        mbdp_pkg::REG_MODE: rdata_out_ff <= {31'h0000_0000, ecl_ff};
        default:
        begin
          rdata_out_ff <= 32'h0000_0000;
          rresp_ff <= mbdp_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_ff && s_axi_rready)
    begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_out_ff;
  assign s_axi_rresp = rresp_ff;

  // Bus cycle: address with latch strobe, hold, strobe for STRB_CYC, release.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff <= mbdp_pkg::HS_IDLE;
      cmd_ff <= mbdp_pkg::CMD_RD;
      cnt_ff <= 2'h0;
      rdata_ff <= 8'h00;
    end
    else
    begin
      unique case (st_ff)
        mbdp_pkg::HS_IDLE:
        begin
          if (start)
          begin
            cmd_ff <= mbdp_pkg::mbdp_cmd_t'(wdat_ff[1:0]);
            st_ff <= mbdp_pkg::HS_ADDR;
          end
        end
        mbdp_pkg::HS_ADDR: st_ff <= mbdp_pkg::HS_HOLD;
        mbdp_pkg::HS_HOLD:
        begin
          cnt_ff <= 2'h0;
          st_ff <= mbdp_pkg::HS_STRB;
        end
        mbdp_pkg::HS_STRB:
        begin
          cnt_ff <= cnt_ff + 2'h1;
          if (cnt_ff == 2'(mbdp_pkg::STRB_CYC - 1))
          begin
            if (!is_wr)
            begin
              rdata_ff <= bus.addr_data_low_port;
            end
            st_ff <= mbdp_pkg::HS_END;
          end
        end
        mbdp_pkg::HS_END: st_ff <= mbdp_pkg::HS_IDLE;
        default: st_ff <= mbdp_pkg::HS_IDLE;
      endcase
    end
  end

  assign strb = (st_ff == mbdp_pkg::HS_STRB);
  assign is_wr = (cmd_ff == mbdp_pkg::CMD_WR);
  assign bus.ale = (st_ff == mbdp_pkg::HS_ADDR);
  assign bus.addr_hi = addr_ff[15:8];
  assign bus.host_ad_o = strb ? wdata_ff : addr_ff[7:0];
  assign bus.host_ad_oe = (st_ff == mbdp_pkg::HS_ADDR) | (st_ff == mbdp_pkg::HS_HOLD) | (strb & is_wr);
  // E-clock style drives E on the read pin and R/W on the write pin.
  assign bus.rd_e = ecl_ff ? strb : ~(strb & (cmd_ff == mbdp_pkg::CMD_RD));
  assign bus.wr_rw = ecl_ff ? ~is_wr : ~(strb & is_wr);
  assign bus.psen_n = ecl_ff | ~(strb & (cmd_ff == mbdp_pkg::CMD_CODE));
endmodule : mbdp_host
`default_nettype wire

// *** rtl/mbdp_pkg.sv ***
package mbdp_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SEL_W = 6;
  localparam int unsigned SEL_SRAM = 4;
  localparam int unsigned SEL_IO = 5;
  localparam int unsigned EPROM_BLKS = 4;
  localparam int unsigned BLK_LSB = 14;
  localparam int unsigned SRAM_DEPTH = 1024;

  // Map for the multiplexed strobe-style host.
  localparam logic [15:0] STB_SRAM_LO = 16'h0000;
  localparam logic [15:0] STB_SRAM_HI = 16'h03ff;
  localparam logic [15:0] STB_IO_LO = 16'hc000;
  localparam logic [15:0] STB_IO_HI = 16'hc0ff;
  localparam logic [15:0] OVL_LO0 = 16'h0000;
  localparam logic [15:0] OVL_HI0 = 16'h3fff;
  localparam logic [15:0] OVL_LO1 = 16'h4000;
  localparam logic [15:0] OVL_HI1 = 16'h7fff;

  // Map for the E-clock host; the external SRAM window at EXT_LO to EXT_HI serves both hosts.
  localparam logic [15:0] EC_IO_LO = 16'h0000;
  localparam logic [15:0] EC_IO_HI = 16'h00ff;
  localparam logic [15:0] EC_SRAM_LO = 16'h1000;
  localparam logic [15:0] EC_SRAM_HI = 16'h13ff;
  localparam logic [15:0] EXT_LO = 16'h2000;
  localparam logic [15:0] EXT_HI = 16'h3fff;

  // Controller register offsets on AXI4-Lite.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_MODE = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int unsigned CLK_NS = 100;
  localparam int unsigned STRB_NS = 300;
  localparam int unsigned STRB_CYC = (STRB_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    CMD_RD = 2'h0,
    CMD_WR = 2'h1,
    CMD_CODE = 2'h2
  } mbdp_cmd_t;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_ADDR = 3'b001,
    HS_HOLD = 3'b011,
    HS_STRB = 3'b010,
    HS_END = 3'b110
  } mbdp_hstate_t;

  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_rng

endpackage : mbdp_pkg

// *** rtl/mbdp_tmp_unused.sv ***
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire
